// >>> pkg/apd_pkg.sv
// package for the serial-line auto power-down controller
`default_nettype none
package apd_pkg;
   // clock and timing
   localparam int CLK_MHZ = 200;
   localparam int IDLE_TIME_US = 30;
   localparam int WAKE_TIME_US = 100;
   localparam int IDLE_CYCLES = IDLE_TIME_US * CLK_MHZ;
   localparam int WAKE_CYCLES = WAKE_TIME_US * CLK_MHZ;
   localparam int CNT_W = 16;

   // channel counts: three drivers, five receivers
   localparam int NUM_TX = 3;
   localparam int NUM_RX = 5;
   localparam int RX2_IDX = 1;

   // variant codes
   localparam logic [1:0] VAR_ONE = 2'h0;
   localparam logic [1:0] VAR_TWO = 2'h1;
   localparam logic [1:0] VAR_BIG = 2'h2;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] OFS_TXDATA = 8'h10;
   localparam logic [7:0] OFS_RXDATA = 8'h14;

   // ctrl fields
   localparam int CTRL_HOLD_ON = 0;
   localparam int CTRL_SHUT_N = 1;
   localparam int CTRL_RXEN_N = 2;
   localparam int CTRL_VAR_LO = 4;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0002;

   // status fields
   localparam int ST_ACTIVITY = 0;
   localparam int ST_PUMP = 1;
   localparam int ST_TXON = 2;
   localparam int ST_MODE_LO = 4;

   // interrupt event bits
   localparam int EV_AUTO_DOWN = 0;
   localparam int EV_WAKE = 1;
   localparam int EV_TX_READY = 2;
   localparam int EV_ACT_CHG = 3;
   localparam int EV_W = 4;

   typedef enum {
      APD_FORCED_OFF, APD_FORCED_ON, APD_AUTO_ON, APD_AUTO_DOWN
   } apd_mode_t;

   typedef struct packed {
      logic [NUM_TX-1:0] data;
      logic [NUM_TX-1:0] oe;
   } apd_tx_t;

   typedef struct packed {
      logic [NUM_RX-1:0] data;
      logic [NUM_RX-1:0] oe;
   } apd_rx_t;
endpackage
`default_nettype wire

// >>> hdl/apd_ctrl.sv
// mode control of a serial-line transceiver with auto power-down
// Behaviour
// - force-off low disables, three-states all transmitters
// - force-off beats force-on, auto; stops pump
// - auto mode only when hold_on low, shutdown high
// - 30us all-idle in auto: pump, drivers off
// - any valid receiver level wakes from auto-down
// - both controls high keeps transmitters, pump on
// - small variants: rx enable high three-states outputs
// - small variants: receivers driven in shutdown if enabled
// - big variant: receivers off forced, on auto
// - big variant: rx2 non-inverted monitor always driven
// - activity flag high iff any valid level
// - activity flag valid in every mode
// - shutdown keeps pump off, transmitter outputs high-impedance
// - transmitters wait 100us after leaving shutdown
// - pump on below 5.5V, off above
// - transmitters and receivers invert; receivers three-state
`default_nettype none
module apd_ctrl
   import apd_pkg::*;
(
   // apb slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic pclk_en,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // line side
   input wire logic [NUM_RX-1:0] rx_line,
   input wire logic [NUM_RX-1:0] rx_valid_level,
   input wire logic rail_above_limit,
   output apd_pkg::apd_tx_t tx_line,
   output apd_pkg::apd_rx_t rx_out,
   output logic rx2_always_on_monitor,
   output logic line_activity,
   output logic pump_enable,
   // interrupt
   output logic irq
);
   import apd_pkg::*;

   logic [31:0] ctrl_reg;
   logic [EV_W-1:0] irq_stat_reg, irq_mask_reg, ev;
   logic [NUM_TX-1:0] txdata_reg;
   logic [CNT_W-1:0] idle_cnt_reg, wake_cnt_reg;
   logic act_reg, tx_ready_reg, auto_down_reg;
   apd_mode_t mode, mode_reg;
   logic hold_on_override, shutdown_override_n, rx_enable_n;
   logic [1:0] variant;
   logic any_valid, shut, shut_prev_reg;
   logic wr, rd, mapped;
   logic we_ctrl, we_irq_stat, we_irq_mask, we_txdata;
   logic [31:0] stat_word;
   logic [NUM_RX-1:0] rx_oe_next;

   assign hold_on_override = ctrl_reg[CTRL_HOLD_ON];
   assign shutdown_override_n = ctrl_reg[CTRL_SHUT_N];
   assign rx_enable_n = ctrl_reg[CTRL_RXEN_N];
   assign variant = ctrl_reg[CTRL_VAR_LO +: 2];
   assign any_valid = |rx_valid_level;

   ////////////////////////////////////////////////////////////////////
   // apb access

   assign wr = psel & penable & pwrite & pclk_en;
   // read data is captured in the setup phase, so the access phase needs
   // no wait state and pready can stay tied high
   assign rd = psel & ~penable & ~pwrite & pclk_en;
   assign pready = 1'b1;
   always_comb begin
      case (paddr)
         OFS_CTRL, OFS_STAT, OFS_IRQ_STAT, OFS_IRQ_MASK,
         OFS_TXDATA, OFS_RXDATA: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   assign pslverr = psel & penable & ~mapped;

   ////////////////////////////////////////////////////////////////////
   // register write decode

   // one strobe per writable register; lane 0 carries every field, so a
   // write without it is dropped rather than half applied
   always_comb begin
      we_ctrl = 1'b0;
      we_irq_stat = 1'b0;
      we_irq_mask = 1'b0;
      we_txdata = 1'b0;
      if (wr && pstrb[0]) begin
         case (paddr)
            OFS_CTRL: begin
               we_ctrl = 1'b1;
            end
            OFS_IRQ_STAT: begin
               we_irq_stat = 1'b1;
            end
            OFS_IRQ_MASK: begin
               we_irq_mask = 1'b1;
            end
            OFS_TXDATA: begin
               we_txdata = 1'b1;
            end
            default: begin
               // read-only and unmapped offsets take no write
               we_ctrl = 1'b0;
            end
         endcase
      end
   end

   // only the low byte holds fields; reserved bits read back as zero

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (we_ctrl) begin
         ctrl_reg <= {24'h0, pwdata[7:0] & 8'h37};
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_mask_reg <= '0;
      end else if (we_irq_mask) begin
         irq_mask_reg <= pwdata[EV_W-1:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         txdata_reg <= '0;
      end else if (we_txdata) begin
         txdata_reg <= pwdata[NUM_TX-1:0];
      end
   end

   // set wins over a write-one clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= '0;
      end else if (pclk_en) begin
         if (we_irq_stat) begin
            irq_stat_reg <= (irq_stat_reg & ~pwdata[EV_W-1:0]) | ev;
         end else begin
            irq_stat_reg <= irq_stat_reg | ev;
         end
      end
   end
   assign irq = |(irq_stat_reg & irq_mask_reg);

   ////////////////////////////////////////////////////////////////////
   // read path

   // status is assembled apart so the read mux stays one word per offset
   always_comb begin
      stat_word = 32'h0;
      stat_word[ST_ACTIVITY] = act_reg;
      stat_word[ST_PUMP] = pump_enable;
      stat_word[ST_TXON] = tx_ready_reg;
      stat_word[ST_MODE_LO +: 2] = 2'(mode_reg);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (rd) begin
         case (paddr)
            OFS_CTRL: prdata <= ctrl_reg;
            OFS_STAT: prdata <= stat_word;
            OFS_IRQ_STAT: prdata <= {28'h0, irq_stat_reg};
            OFS_IRQ_MASK: prdata <= {28'h0, irq_mask_reg};
            OFS_TXDATA: prdata <= {29'h0, txdata_reg};
            OFS_RXDATA: prdata <= {27'h0, rx_out.data};
            default: prdata <= 32'h0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mode selection

   // force-off wins over everything, then force-on, then the idle timer
   always_comb begin
      if (!shutdown_override_n) begin
         mode = APD_FORCED_OFF;
      end else if (hold_on_override) begin
         mode = APD_FORCED_ON;
      end else if (auto_down_reg && !any_valid) begin
         mode = APD_AUTO_DOWN;
      end else begin
         mode = APD_AUTO_ON;
      end
   end

   // idle timer only runs in auto mode; any valid level restarts it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idle_cnt_reg <= '0;
         auto_down_reg <= 1'b0;
      end else if (pclk_en) begin
         if (!shutdown_override_n || hold_on_override || any_valid) begin
            idle_cnt_reg <= '0;
            auto_down_reg <= 1'b0;
         end else if (idle_cnt_reg >= CNT_W'(IDLE_CYCLES - 1)) begin
            auto_down_reg <= 1'b1;
         end else begin
            idle_cnt_reg <= idle_cnt_reg + 1'b1;
         end
      end
   end

   // registered copy feeds status and the entry-edge detector below
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= APD_AUTO_ON;
      end else if (pclk_en) begin
         mode_reg <= mode;
      end
   end

   assign shut = (mode == APD_FORCED_OFF) || (mode == APD_AUTO_DOWN);

   // wake-up delay after any shutdown; also applied out of reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wake_cnt_reg <= '0;
         tx_ready_reg <= 1'b0;
         shut_prev_reg <= 1'b1;
      end else if (pclk_en) begin
         shut_prev_reg <= shut;
         if (shut) begin
            wake_cnt_reg <= '0;
            tx_ready_reg <= 1'b0;
         end else if (wake_cnt_reg >= CNT_W'(WAKE_CYCLES - 1)) begin
            tx_ready_reg <= 1'b1;
         end else begin
            wake_cnt_reg <= wake_cnt_reg + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // outputs

   // on-off pump regulation, gated off in any shutdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pump_enable <= 1'b0;
      end else if (pclk_en) begin
         pump_enable <= !shut && !rail_above_limit;
      end
   end

   // drivers wait for tx_ready so a rail still pumping up never reaches
   // the cable; the price is a silent interval after every wake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_line <= '0;
      end else if (pclk_en) begin
         tx_line.data <= ~txdata_reg;
         tx_line.oe <= {NUM_TX{tx_ready_reg && !shut}};
      end
   end

   // small variants keep receivers alive in shutdown so the host can
   // still see a ring; the big variant relies on the monitor copy instead
   always_comb begin
      case (variant)
         VAR_BIG: begin
            // big variant ignores rx enable
            rx_oe_next = {NUM_RX{mode != APD_FORCED_OFF}};
         end
         VAR_TWO: begin
            rx_oe_next = {3'h0, {2{!rx_enable_n}}};
         end
         VAR_ONE: begin
            rx_oe_next = {4'h0, !rx_enable_n};
         end
         default: begin
            // the spare code behaves as the one-channel part
            rx_oe_next = {4'h0, !rx_enable_n};
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_out <= '0;
      end else if (pclk_en) begin
         rx_out.data <= ~rx_line;
         rx_out.oe <= rx_oe_next;
      end
   end

   // monitor copy is non-inverted and never three-stated
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx2_always_on_monitor <= 1'b0;
      end else if (pclk_en) begin
         rx2_always_on_monitor <= rx_line[RX2_IDX];
      end
   end

   // the flag is never gated by mode: software uses it to decide when
   // to leave a forced shutdown
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_reg <= 1'b0;
      end else if (pclk_en) begin
         act_reg <= any_valid;
      end
   end
   assign line_activity = act_reg;

   ////////////////////////////////////////////////////////////////////
   // interrupt events

   // events are one-cycle pulses; the sticky bits hold them for software
   always_comb begin
      ev = '0;
      // entry edge of auto-down, seen against last cycle's mode
      ev[EV_AUTO_DOWN] = (mode == APD_AUTO_DOWN) &&
                         (mode_reg != APD_AUTO_DOWN);
      // any way out of shutdown, forced or automatic
      ev[EV_WAKE] = !shut && shut_prev_reg;
      // the cycle before tx_ready rises
      ev[EV_TX_READY] = !shut && !tx_ready_reg &&
                        wake_cnt_reg >= CNT_W'(WAKE_CYCLES - 1);
      // the flag is about to change at the next edge
      ev[EV_ACT_CHG] = any_valid != act_reg;
   end
endmodule
`default_nettype wire

// >>> dv/apd_chk.sv
// port checker for the auto power-down controller
`default_nettype none
module apd_chk
   import apd_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // line side
   input wire logic [NUM_RX-1:0] rx_line,
   input wire logic [NUM_RX-1:0] rx_valid_level,
   input wire logic rail_above_limit,
   input wire apd_pkg::apd_tx_t tx_line,
   input wire apd_pkg::apd_rx_t rx_out,
   input wire logic rx2_always_on_monitor,
   input wire logic line_activity,
   input wire logic pump_enable
);
   logic [15:0] up_cnt;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////////////////////////////////////
   // edges since reset; saturates so it never wraps back into the window
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         up_cnt <= 16'h0000;
      else if (up_cnt != 16'hffff)
         up_cnt <= up_cnt + 16'h0001;
   end
   ////////////////////////////////////////////////////////////////////////
   a_act_flag: assert property ($past(presetn) |->
      line_activity == $past(|rx_valid_level))
      else $error("activity flag does not follow valid levels");
   a_mon_copy: assert property ($past(presetn) |->
      rx2_always_on_monitor == $past(rx_line[RX2_IDX]))
      else $error("monitor output is not a copy of receiver two");
   a_rx_invert: assert property ($past(presetn) |->
      rx_out.data == ~$past(rx_line))
      else $error("receiver data is not inverted");
   a_pump_rail: assert property (rail_above_limit |=>
      !pump_enable)
      else $error("pump runs with rail above limit");
   a_tx_wake: assert property (up_cnt < WAKE_CYCLES |->
      tx_line.oe == 3'h0)
      else $error("transmitters on before wake delay");
   a_tx_all: assert property (tx_line.oe == 3'h0 ||
      tx_line.oe == 3'h7)
      else $error("transmitters enabled partly");
   a_pump_tx_off: assert property (
      !pump_enable && !$past(rail_above_limit) |=> tx_line.oe == 3'h0)
      else $error("transmitters driven in shutdown");
   a_rx_oe_shape: assert property (rx_out.oe == 5'h00 ||
      rx_out.oe == 5'h01 || rx_out.oe == 5'h03 || rx_out.oe == 5'h1f)
      else $error("receiver enables form no legal pattern");
   c_pump_off: cover property ($fell(pump_enable));
   c_tx_on: cover property ($rose(tx_line.oe[0]));
   c_rx_all: cover property (rx_out.oe == 5'h1f);
endmodule
`default_nettype wire

// >>> dv/apd_line_model.sv
// remote serial equipment driving the receiver inputs
`default_nettype none
module apd_line_model
   import apd_pkg::*;
(
   // clock
   input wire logic pclk,
   // cable activity per receiver
   input wire logic [NUM_RX-1:0] active,
   // receiver inputs
   output var logic [NUM_RX-1:0] rx_line,
   output var logic [NUM_RX-1:0] rx_valid_level
);
   logic [4:0] cnt;
   initial begin
      cnt = 5'h00;
      rx_line = 5'h00;
      rx_valid_level = 5'h00;
   end
   always @(posedge pclk) begin
      cnt <= cnt + 5'h01;
      // a silent line toggles so a stale level never passes for data
      rx_line <= (active & cnt) | (~active & ~rx_line);
      rx_valid_level <= active;
   end
endmodule
`default_nettype wire

// >>> dv/apd_ctrl_test.sv
// self-checking bench for the auto power-down controller
`default_nettype none
module apd_ctrl_test;
   timeunit 1ns;
   timeprecision 1ps;
   import apd_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, rail = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err_seen, mon, line_activity, pump_enable, irq;
   logic [NUM_RX-1:0] act = 5'h1f, rx_line, rx_valid_level;
   apd_tx_t tx_line;
   apd_rx_t rx_out;
   int num_errors = 0, n_tests = 0, cyc = 0;
   initial forever #2.5 pclk = ~pclk;
   apd_ctrl uut (.pclk(pclk), .presetn(presetn), .pclk_en(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rx_line(rx_line),
      .rx_valid_level(rx_valid_level), .rail_above_limit(rail),
      .tx_line(tx_line), .rx_out(rx_out), .rx2_always_on_monitor(mon),
      .line_activity(line_activity), .pump_enable(pump_enable), .irq(irq));
   apd_line_model far (.pclk(pclk), .active(act), .rx_line(rx_line),
      .rx_valid_level(rx_valid_level));
   ////////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("errors %0d tests %0d", num_errors, n_tests);
      if (num_errors == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one idle edge first so back-to-back calls never reassign psel at once
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      err_seen = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rx_case(input logic [31:0] ctrl, input logic [4:0] exp);
      apb(1'b1, OFS_CTRL, ctrl);
      tick(3);
      chk(rx_out.oe, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_wake;
      tick(WAKE_CYCLES - 10);
      chk(tx_line.oe, 3'h0);
      apb(1'b1, OFS_TXDATA, 32'h5);
      tick(20);
      chk(tx_line, 6'h17);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h27);
   endtask
   task automatic t_off;
      apb(1'b1, OFS_CTRL, 32'h21);
      tick(3);
      chk({tx_line.oe, pump_enable, rx_out.oe}, 9'h0);
      chk(line_activity, 1'b1);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h01);
      act <= 5'h00;
      tick(3);
      chk(line_activity, 1'b0);
      rx_case(32'h00, 5'h01);
      rx_case(32'h10, 5'h03);
      rx_case(32'h14, 5'h00);
   endtask
   task automatic t_on;
      apb(1'b1, OFS_CTRL, 32'h23);
      tick(IDLE_CYCLES + 100);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd, 32'h12);
      chk(rx_out.oe, 5'h1f);
      rail <= 1'b1;
      tick(3);
      chk(pump_enable, 1'b0);
      rail <= 1'b0;
      tick(3);
      chk(pump_enable, 1'b1);
   endtask
   task automatic t_auto;
      apb(1'b1, OFS_IRQ_STAT, 32'hf);
      apb(1'b1, OFS_IRQ_MASK, 32'h1);
      act <= 5'h04;
      apb(1'b1, OFS_CTRL, 32'h22);
      act <= 5'h00;
      tick(IDLE_CYCLES - 1000);
      act <= 5'h10;
      tick(2);
      act <= 5'h00;
      tick(IDLE_CYCLES - 1000);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd & 32'h30, 32'h20);
      chk(irq, 1'b0);
      tick(1100);
      chk(irq, 1'b1);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd & 32'h32, 32'h30);
      apb(1'b1, OFS_IRQ_STAT, 32'h1);
      tick(1);
      chk(irq, 1'b0);
      act <= 5'h02;
      tick(2);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(rd & 32'h30, 32'h20);
      chk(irq, 1'b0);
      apb(1'b0, 8'h40, 32'h0);
      chk({err_seen, rd}, 33'h100000000);
   endtask
   ////////////////////////////////////////////////////////////////////////
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 50000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      tick(5);
      presetn <= 1'b1;
      t_wake();
      t_off();
      t_on();
      t_auto();
      end_sim();
   end
endmodule
bind apd_ctrl apd_chk u_chk (.pclk(pclk), .presetn(presetn),
   .rx_line(rx_line), .rx_valid_level(rx_valid_level),
   .rail_above_limit(rail_above_limit), .tx_line(tx_line),
   .rx_out(rx_out), .rx2_always_on_monitor(rx2_always_on_monitor),
   .line_activity(line_activity), .pump_enable(pump_enable));
`default_nettype wire
